// file: rtl/pgc_config_reg.sv
/*
 peripheral general configuration register bank behind an AXI4-Lite slave.
 assumes one clock, asynchronous active-low reset, and a strap pin from outside the clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
module pgc_config_reg
   import pgc_pkg::*;
#(
   parameter int ADDR_W = 16
) (
   // clock, reset, enable
   input  wire logic              clock,
   input  wire logic              rst_b,
   input  wire logic              ce,
   // axi4-lite write address
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // axi4-lite write response
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // axi4-lite read
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // strap pin
   input  wire logic              fixed_route_strap,
   // peripheral controls
   output logic [7:0]             uncached_accel_en,
   output logic                   host_b_clock_gate,
   output logic                   host_b_access_allow,
   output logic                   host_b_phy_hold,
   output logic                   host_b_ctrl_hold,
   output logic                   host_a_clock_gate,
   output logic                   host_a_access_allow,
   output logic                   host_a_phy_hold,
   output logic                   host_a_ctrl_hold,
   output logic                   mac_b_clock_gate,
   output logic                   mac_b_pause_enable,
   output logic                   mac_a_clock_gate,
   output logic                   mac_a_pause_enable,
   output logic [1:0]             host_phy_ref_sel,
   output logic                   host_wide_dma_addr,
   output logic                   fixed_addr_routing,
   output logic [31:0]            general_config_next
);

   // ==========================================================
   // elaboration checks
   if (ADDR_W < 12 || ADDR_W > 16) begin : g_bad_addr_w
      $error("ADDR_W must lie between 12 and 16");
   end

   // ==========================================================
   // helpers
   function automatic logic pgc_hit(input logic [ADDR_W-1:0] a, input logic [15:0] off);
      pgc_hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
   endfunction : pgc_hit

   function automatic logic [31:0] pgc_merge(input logic [31:0] old, input logic [31:0] dat,
                                             input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = dat[8*i +: 8];
         end
      end
      pgc_merge = res;
   endfunction : pgc_merge

   // ==========================================================
   // state
   logic [31:0]       cfg;
   logic [31:0]       next_cfg;
   logic [31:0]       next_general_config_next;
   logic [2:0]        strap_sync;
   logic [2:0]        next_strap_sync;
   logic              strap_q;
   logic              next_strap_q;
   logic              next_fixed_addr_routing;
   logic [ADDR_W-1:0] aw_addr;
   logic [ADDR_W-1:0] next_aw_addr;
   logic [31:0]       wdata_q;
   logic [31:0]       next_wdata_q;
   logic [3:0]        wstrb_q;
   logic [3:0]        next_wstrb_q;
   logic              next_awready;
   logic              next_wready;
   logic              next_bvalid;
   logic [1:0]        next_bresp;
   logic              next_arready;
   logic              next_rvalid;
   logic [31:0]       next_rdata;
   logic [1:0]        next_rresp;
   logic              do_wr;
   logic              wr_cfg;
   logic              rd_take;

   assign do_wr   = ce && !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign wr_cfg  = do_wr && pgc_hit(aw_addr, PGC_CFG_OFFSET);
   assign rd_take = ce && s_axi_arvalid && s_axi_arready;

   // ==========================================================
   // strap synchroniser and filter
   always_comb begin
      next_strap_sync = strap_sync;
      next_strap_q    = strap_q;
      if (ce) begin
         next_strap_sync = {strap_sync[1:0], fixed_route_strap};
         // accept a change only once stages two and three agree
         if (strap_sync[1] == strap_sync[2]) begin
            next_strap_q = strap_sync[2];
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         strap_sync <= 3'h0;
         strap_q    <= 1'b0;
      end else begin
         strap_sync <= next_strap_sync;
         strap_q    <= next_strap_q;
      end
   end

   // ==========================================================
   // write channel
   always_comb begin
      next_awready             = s_axi_awready;
      next_wready              = s_axi_wready;
      next_aw_addr             = aw_addr;
      next_wdata_q             = wdata_q;
      next_wstrb_q             = wstrb_q;
      next_bvalid              = s_axi_bvalid;
      next_bresp               = s_axi_bresp;
      next_cfg                 = cfg;
      next_general_config_next = general_config_next;
      if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            next_awready = 1'b0;
            next_aw_addr = s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            next_wready  = 1'b0;
            next_wdata_q = s_axi_wdata;
            next_wstrb_q = s_axi_wstrb;
         end
         if (do_wr) begin
            next_bvalid = 1'b1;
            next_bresp  = PGC_RESP_OKAY;
            // reserved bits 23:16 are stored like any other
            if (wr_cfg) begin
               next_cfg = pgc_merge(cfg, wdata_q, wstrb_q);
            end else if (pgc_hit(aw_addr, PGC_NEXT_OFFSET)) begin
               next_general_config_next = pgc_merge(general_config_next, wdata_q, wstrb_q);
            end else begin
               next_bresp = PGC_RESP_SLVERR;
            end
         end
         if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid  = 1'b0;
            next_awready = 1'b1;
            next_wready  = 1'b1;
         end
      end
   end

   // ==========================================================
   // read channel
   always_comb begin
      next_arready = s_axi_arready;
      next_rvalid  = s_axi_rvalid;
      next_rdata   = s_axi_rdata;
      next_rresp   = s_axi_rresp;
      if (ce) begin
         if (rd_take) begin
            next_arready = 1'b0;
            next_rvalid  = 1'b1;
            next_rresp   = PGC_RESP_OKAY;
            if (pgc_hit(s_axi_araddr, PGC_CFG_OFFSET)) begin
               next_rdata            = cfg;
               next_rdata[PGC_ROUTE] = cfg[PGC_ROUTE] | strap_q;
            end else if (pgc_hit(s_axi_araddr, PGC_NEXT_OFFSET)) begin
               next_rdata = general_config_next;
            end else begin
               next_rdata = 32'h0;
               next_rresp = PGC_RESP_SLVERR;
            end
         end
         if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid  = 1'b0;
            next_arready = 1'b1;
         end
      end
   end

   // ==========================================================
   // effective routing
   always_comb begin
      next_fixed_addr_routing = fixed_addr_routing;
      if (ce) begin
         next_fixed_addr_routing = cfg[PGC_ROUTE] | strap_q;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_awready       <= 1'b1;
         s_axi_wready        <= 1'b1;
         aw_addr             <= '0;
         wdata_q             <= 32'h0;
         wstrb_q             <= 4'h0;
         s_axi_bvalid        <= 1'b0;
         s_axi_bresp         <= PGC_RESP_OKAY;
         s_axi_arready       <= 1'b1;
         s_axi_rvalid        <= 1'b0;
         s_axi_rdata         <= 32'h0;
         s_axi_rresp         <= PGC_RESP_OKAY;
         cfg                 <= PGC_CFG_RESET;
         general_config_next <= PGC_NEXT_RESET;
         fixed_addr_routing  <= PGC_CFG_RESET[PGC_ROUTE];
      end else begin
         s_axi_awready       <= next_awready;
         s_axi_wready        <= next_wready;
         aw_addr             <= next_aw_addr;
         wdata_q             <= next_wdata_q;
         wstrb_q             <= next_wstrb_q;
         s_axi_bvalid        <= next_bvalid;
         s_axi_bresp         <= next_bresp;
         s_axi_arready       <= next_arready;
         s_axi_rvalid        <= next_rvalid;
         s_axi_rdata         <= next_rdata;
         s_axi_rresp         <= next_rresp;
         cfg                 <= next_cfg;
         general_config_next <= next_general_config_next;
         fixed_addr_routing  <= next_fixed_addr_routing;
      end
   end

   // ==========================================================
   // peripheral controls, straight from the register
   assign uncached_accel_en   = cfg[PGC_UCA_LSB +: PGC_UCA_W];
   assign host_b_clock_gate   = cfg[PGC_HB_CLK];
   assign host_b_access_allow = cfg[PGC_HB_ACC];
   assign host_b_phy_hold     = cfg[PGC_HB_PHY];
   assign host_b_ctrl_hold    = cfg[PGC_HB_CTRL];
   assign host_a_clock_gate   = cfg[PGC_HA_CLK];
   assign host_a_access_allow = cfg[PGC_HA_ACC];
   assign host_a_phy_hold     = cfg[PGC_HA_PHY];
   assign host_a_ctrl_hold    = cfg[PGC_HA_CTRL];
   assign mac_b_clock_gate    = cfg[PGC_MB_CLK];
   assign mac_b_pause_enable  = cfg[PGC_MB_PAUSE];
   assign mac_a_clock_gate    = cfg[PGC_MA_CLK];
   assign mac_a_pause_enable  = cfg[PGC_MA_PAUSE];
   assign host_phy_ref_sel    = cfg[PGC_REF_LSB +: 2];
   assign host_wide_dma_addr  = cfg[PGC_DMA64];

   // ==========================================================
   // checks
   a_strap_forces_route: assert property (@(posedge clock) disable iff (!rst_b)
      (ce && strap_q) |=> fixed_addr_routing)
      else $error("fixed routing not forced by strap");

   a_route_follows_bit: assert property (@(posedge clock) disable iff (!rst_b)
      (ce && !strap_q && !cfg[PGC_ROUTE]) |=> !fixed_addr_routing)
      else $error("fixed routing high without cause");

   a_read_route_one: assert property (@(posedge clock) disable iff (!rst_b)
      (rd_take && strap_q && pgc_hit(s_axi_araddr, PGC_CFG_OFFSET)) |=> s_axi_rdata[PGC_ROUTE])
      else $error("route bit read as zero under strap");

   a_write_b_phy: assert property (@(posedge clock) disable iff (!rst_b)
      (wr_cfg && wstrb_q[1]) |=> host_b_phy_hold == $past(wdata_q[PGC_HB_PHY]))
      else $error("second phy hold does not follow write");

   a_write_a_ctrl: assert property (@(posedge clock) disable iff (!rst_b)
      (wr_cfg && wstrb_q[1]) |=> host_a_ctrl_hold == $past(wdata_q[PGC_HA_CTRL]))
      else $error("first controller hold does not follow write");

   a_write_uca: assert property (@(posedge clock) disable iff (!rst_b)
      (wr_cfg && wstrb_q[3]) |=> uncached_accel_en == $past(wdata_q[31:24]))
      else $error("acceleration enables do not follow write");

   a_write_mac_low: assert property (@(posedge clock) disable iff (!rst_b)
      (wr_cfg && wstrb_q[0]) |=> {mac_a_clock_gate, mac_a_pause_enable, host_phy_ref_sel}
                                 == $past(wdata_q[5:2]))
      else $error("low byte fields do not follow write");

   a_unstrobed_keeps: assert property (@(posedge clock) disable iff (!rst_b)
      (wr_cfg && !wstrb_q[1]) |=> $stable(host_b_clock_gate) && $stable(host_a_access_allow))
      else $error("unstrobed byte changed");

   a_write_answer: assert property (@(posedge clock) disable iff (!rst_b)
      (ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce)
      |=> ##1 (s_axi_bvalid || !ce))
      else $error("write response late");

   a_bvalid_holds: assert property (@(posedge clock) disable iff (!rst_b)
      (s_axi_bvalid && !(ce && s_axi_bready)) |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");

endmodule : pgc_config_reg
`default_nettype wire

// file: rtl/pgc_pkg.sv
/*
 peripheral general configuration: shared offsets, field positions, reset values.
 assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package pgc_pkg;
   // ==========================================================
   // register map
   localparam logic [15:0] PGC_CFG_OFFSET  = 16'h0430;
   localparam logic [15:0] PGC_NEXT_OFFSET = 16'h0434;
   localparam logic [31:0] PGC_CFG_RESET   = 32'h00f9bbf2;
   localparam logic [31:0] PGC_NEXT_RESET  = 32'h12099900;
   // ==========================================================
   // field positions
   localparam int PGC_UCA_LSB  = 24;
   localparam int PGC_UCA_W    = 8;
   localparam int PGC_HB_CLK   = 15;
   localparam int PGC_HB_ACC   = 14;
   localparam int PGC_HB_PHY   = 13;
   localparam int PGC_HB_CTRL  = 12;
   localparam int PGC_HA_CLK   = 11;
   localparam int PGC_HA_ACC   = 10;
   localparam int PGC_HA_PHY   = 9;
   localparam int PGC_HA_CTRL  = 8;
   localparam int PGC_MB_CLK   = 7;
   localparam int PGC_MB_PAUSE = 6;
   localparam int PGC_MA_CLK   = 5;
   localparam int PGC_MA_PAUSE = 4;
   localparam int PGC_REF_LSB  = 2;
   localparam int PGC_DMA64    = 1;
   localparam int PGC_ROUTE    = 0;
   // ==========================================================
   // encodings
   localparam logic [1:0] PGC_REF_XTAL     = 2'h0;
   localparam logic [1:0] PGC_REF_INTERNAL = 2'h2;
   localparam logic [1:0] PGC_RESP_OKAY    = 2'h0;
   localparam logic [1:0] PGC_RESP_SLVERR  = 2'h2;
   localparam int         PGC_SYNC_STAGES  = 3;
endpackage : pgc_pkg

// file: tb/pgc_config_reg_tb_top.sv
/*
 self-checking bench for the peripheral general configuration register bank.
 assumes the design carries its own assertions; the bench drives axi4-lite and the strap itself.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin n_mismatch++; \
   $display("Error %s expected %h seen %h", nm, ex, got); end end
module pgc_config_reg_tb_top;
   import pgc_pkg::*;
   // ==========================================================
   // signals
   logic        clock, rst_b, ce, strap;
   logic [15:0] s_axi_awaddr, s_axi_araddr;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata, cfg, nxt, d, rd;
   logic [3:0]  s_axi_wstrb, s;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   logic [7:0]  uncached_accel_en;
   logic [1:0]  host_phy_ref_sel;
   logic [31:0] general_config_next;
   logic        hb_clk, hb_acc, hb_phy, hb_ctl, ha_clk, ha_acc, ha_phy, ha_ctl;
   logic        mb_clk, mb_pause, ma_clk, ma_pause, host_wide_dma_addr, fixed_addr_routing;
   int          n_mismatch, samples_checked;
   // ==========================================================
   // design
   pgc_config_reg #(.ADDR_W(16)) DUT (.clock(clock), .rst_b(rst_b), .ce(ce),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .fixed_route_strap(strap),
      .uncached_accel_en(uncached_accel_en), .host_b_clock_gate(hb_clk), .host_b_access_allow(hb_acc),
      .host_b_phy_hold(hb_phy), .host_b_ctrl_hold(hb_ctl), .host_a_clock_gate(ha_clk),
      .host_a_access_allow(ha_acc), .host_a_phy_hold(ha_phy), .host_a_ctrl_hold(ha_ctl),
      .mac_b_clock_gate(mb_clk), .mac_b_pause_enable(mb_pause), .mac_a_clock_gate(ma_clk),
      .mac_a_pause_enable(ma_pause), .host_phy_ref_sel(host_phy_ref_sel),
      .host_wide_dma_addr(host_wide_dma_addr), .fixed_addr_routing(fixed_addr_routing),
      .general_config_next(general_config_next));
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   // ==========================================================
   // bus tasks and model
   task automatic axi_wr(input logic [15:0] a, input logic [31:0] wd, input logic [3:0] ws);
      int n, bw;
      @(posedge clock);
      // bready may come late so a pending response must wait for it
      bw = $urandom % 5;
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= wd;
      s_axi_wstrb   <= ws;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= (bw == 0);
      n = 0;
      do begin
         @(posedge clock);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (n >= bw) s_axi_bready <= 1'b1;
      end while (!(s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) && n < 50);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n >= 50) begin
         n_mismatch++;
         $display("Error bvalid expected 1 seen 0");
      end
      for (int i = 0; i < 4; i++) begin
         if (ws[i] && a == PGC_CFG_OFFSET) cfg[8*i+:8] = wd[8*i+:8];
         if (ws[i] && a == PGC_NEXT_OFFSET) nxt[8*i+:8] = wd[8*i+:8];
      end
   endtask : axi_wr
   task automatic rd_chk(input logic [15:0] a, input logic [31:0] ex, input logic [1:0] exr);
      int n;
      @(posedge clock);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 50);
      rd = s_axi_rdata;
      s_axi_rready <= 1'b0;
      if (n >= 50) begin
         n_mismatch++;
         $display("Error rvalid expected 1 seen 0");
      end
      `CHK("rdata", ex, rd)
      `CHK("rresp", exr, s_axi_rresp)
   endtask : rd_chk
   task automatic check_outs;
      @(negedge clock);
      `CHK("accel", cfg[31:24], uncached_accel_en)
      `CHK("host", cfg[15:8], {hb_clk, hb_acc, hb_phy, hb_ctl, ha_clk, ha_acc, ha_phy, ha_ctl})
      `CHK("mac", cfg[7:4], {mb_clk, mb_pause, ma_clk, ma_pause})
      `CHK("ref", cfg[3:2], host_phy_ref_sel)
      `CHK("dma", cfg[1], host_wide_dma_addr)
      `CHK("route", cfg[0] | strap, fixed_addr_routing)
      `CHK("next", nxt, general_config_next)
   endtask : check_outs
   task automatic do_reset;
      rst_b <= 1'b0;
      repeat (5) @(posedge clock);
      rst_b <= 1'b1;
      cfg = PGC_CFG_RESET;
      nxt = PGC_NEXT_RESET;
   endtask : do_reset
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_of_test
   // ==========================================================
   // tests
   initial begin
      {rst_b, ce, strap, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 8'h40;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      n_mismatch = 0;
      samples_checked = 0;
      void'($urandom(32'h4317));
      do_reset();
      check_outs();
      rd_chk(PGC_CFG_OFFSET, cfg, PGC_RESP_OKAY);
      rd_chk(PGC_NEXT_OFFSET, nxt, PGC_RESP_OKAY);
      $display("test reset values done");
      for (int k = 0; k < 16; k++) begin
         d = $urandom;
         d[3:2] = k[0] ? PGC_REF_INTERNAL : PGC_REF_XTAL;
         s = (k < 4) ? 4'hf : 4'($urandom);
         axi_wr(PGC_CFG_OFFSET, d, s);
         `CHK("bresp", PGC_RESP_OKAY, resp)
         check_outs();
         rd_chk(PGC_CFG_OFFSET, cfg, PGC_RESP_OKAY);
         axi_wr(PGC_NEXT_OFFSET, $urandom, 4'($urandom));
         rd_chk(PGC_NEXT_OFFSET, nxt, PGC_RESP_OKAY);
      end
      $display("test random writes done");
      axi_wr(PGC_CFG_OFFSET, 32'h00000000, 4'h1);
      strap <= 1'b1;
      repeat (8) @(posedge clock);
      check_outs();
      rd_chk(PGC_CFG_OFFSET, cfg | 32'h1, PGC_RESP_OKAY);
      strap <= 1'b0;
      repeat (8) @(posedge clock);
      check_outs();
      rd_chk(PGC_CFG_OFFSET, cfg, PGC_RESP_OKAY);
      $display("test strap override done");
      // clock enable low must freeze the strap filter and the routing output
      ce    <= 1'b0;
      strap <= 1'b1;
      repeat (8) @(posedge clock);
      @(negedge clock);
      `CHK("route frozen", cfg[0], fixed_addr_routing)
      @(posedge clock);
      ce <= 1'b1;
      repeat (8) @(posedge clock);
      check_outs();
      rd_chk(PGC_CFG_OFFSET, cfg | 32'h1, PGC_RESP_OKAY);
      strap <= 1'b0;
      repeat (8) @(posedge clock);
      check_outs();
      $display("test clock enable done");
      axi_wr(16'h0500, 32'hffffffff, 4'hf);
      `CHK("bresp", PGC_RESP_SLVERR, resp)
      check_outs();
      rd_chk(16'h042c, 32'h0, PGC_RESP_SLVERR);
      $display("test unmapped access done");
      do_reset();
      check_outs();
      rd_chk(PGC_CFG_OFFSET, cfg, PGC_RESP_OKAY);
      $display("test second reset done");
      end_of_test();
   end
   initial begin
      repeat (20000) @(posedge clock);
      n_mismatch++;
      end_of_test();
   end
endmodule : pgc_config_reg_tb_top
`undef CHK
`default_nettype wire
